// File: pkg/pei_pkg.sv
package pei_pkg;
  // channel and flag layout
  localparam int NCH   = 4;
  localparam int NFLAG = 38;
  localparam int NCAT  = 8;
  // flag offsets inside the latched bank
  localparam int F_SUP = 0;
  localparam int F_STA = 4;
  localparam int F_CUR = 8;
  localparam int F_CLS = 18;
  localparam int F_DET = 22;
  localparam int F_DIS = 26;
  localparam int F_PG  = 30;
  localparam int F_PE  = 34;
  // pair cut flags sit above the eight readable current flags
  localparam int F_PAIR = F_CUR + 8;
  // summary bit to flag slice, indexed by summary bit position
  localparam int CAT_OFS [NCAT] = '{F_PE, F_PG, F_DIS, F_DET, F_CLS, F_CUR, F_STA, F_SUP};
  localparam int CAT_W   [NCAT] = '{4, 4, 4, 4, 4, 10, 4, 4};
  localparam int CAT_CUR = 5;
  // power supply undervoltage flag is set at reset, so summary bit 7 is too
  localparam logic [NFLAG-1:0] FLAG_RST = 38'h00_0000_0004;
  // command codes
  localparam logic [7:0] CMD_SUMMARY  = 8'h00;
  localparam logic [7:0] CMD_MASK     = 8'h01;
  localparam logic [7:0] CMD_EVT_BASE = 8'h02;
  localparam logic [7:0] CMD_EVT_PAIR = 8'h0a;
  localparam logic [7:0] CMD_GEN_MASK = 8'h17;
  localparam logic [7:0] CMD_RESET    = 8'h1a;
  // field positions and reset values
  localparam int         GIE_BIT     = 7;
  localparam int         RST_CLR_BIT = 7;
  localparam logic [7:0] MASK_RST    = 8'h80;
  localparam logic       GIE_RST     = 1'b0;
  // serial slave states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_CMD   = 9'h008,
    ST_CACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } pei_i2c_st_t;
endpackage

// File: hw/pei_flag_bank.sv
`timescale 1ns/1ps
module pei_flag_bank
  import pei_pkg::*;
#(
  parameter int               W   = NFLAG,
  parameter logic [W-1:0]     RST = FLAG_RST
) (
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  input  wire logic [W-1:0]   set_in,
  input  wire logic [W-1:0]   clr_in,
  output logic      [W-1:0]   flag_out
);
  // one sticky latch per event flag
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        flag_out[i] <= RST[i];
      end else if (set_in[i]) begin
        flag_out[i] <= 1'b1; // set beats a same-cycle clear
      end else if (clr_in[i]) begin
        flag_out[i] <= 1'b0;
      end
    end
  end
endmodule // pei_flag_bank

// File: hw/pei_event_irq.sv
// Operation
// - summary bits active high, one per category
// - reading category event register clears its bit
// - reset command bit 7 clears all bits
// - interrupt when set, mask one, enable one
// - bit 7 is supply faults, resets one
// - bit 5 is overload, pair cut, limit
// - bit 4 is classification done, resets zero
// - summary at code 00h, read only
// - bit 3 is detection cycle done
// - bit 2 is disconnect events
// - bit 1 is power good changes
// - bit 0 is power enable changes
`timescale 1ns/1ps
module pei_event_irq #(
  parameter logic [6:0]                 I2C_ADDR = 7'h20
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n_out,
  output logic                          int_n_out,
  input  wire logic                     thermal_shutdown_flag_in,
  input  wire logic                     logic_supply_uv_flag_in,
  input  wire logic                     power_supply_uv_flag_in,
  input  wire logic                     sram_fault_flag_in,
  input  wire logic [pei_pkg::NCH-1:0]  start_fault_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  overload_cut_ch_in,
  input  wire logic                     overload_cut_pair_a_in,
  input  wire logic                     overload_cut_pair_b_in,
  input  wire logic [pei_pkg::NCH-1:0]  current_limit_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  class_cycle_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  detect_cycle_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  disconnect_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  pgood_change_ch_in,
  input  wire logic [pei_pkg::NCH-1:0]  pwr_enable_change_ch_in
);
  import pei_pkg::*;

  logic              rst_s1_q, rst_s2_q, rst_n;
  logic              scl_s1_q, scl_s2_q, scl_p_q;
  logic              sda_s1_q, sda_s2_q, sda_p_q;
  logic              scl_rise, scl_fall, i2c_start, i2c_stop, addr_hit;
  pei_i2c_st_t       st_q, st_d;
  logic [2:0]        cnt_q;
  logic              full_q, mack_q, oe_n_q, oe_n_d;
  logic [7:0]        sh_q, tx_q, ptr_q;
  logic              rd_stb, wr_stb, glob_clr;
  logic [7:0]        mask_q, event_summary, rd_data, evt_byte;
  logic              global_irq_enable_q, int_n_q, irq_req;
  logic [NFLAG-1:0]  set_vec, clr_vec, flags;
  logic [NCAT-1:0]   cat_clr;
  logic [7:0]        cat_byte [NCAT];
  logic [7:0]        evt_idx;
  logic              evt_hit;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // bus pins come from outside, two flops before use plus a history stage
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {scl_in, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {sda_in, sda_s1_q, sda_s2_q};
    end
  end

  // bus conditions seen on the synchronised copies
  assign scl_rise  = scl_s2_q & ~scl_p_q;
  assign scl_fall  = ~scl_s2_q & scl_p_q;
  assign i2c_start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign i2c_stop  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign addr_hit  = (sh_q[7:1] == I2C_ADDR);

  // frame sequencing; start and stop act at once, other moves happen on a falling clock so sda changes while low
  always_comb begin
    st_d = st_q;
    if (i2c_start) begin
      st_d = ST_ADDR;
    end else if (i2c_stop) begin
      st_d = ST_IDLE;
    end else if (scl_fall) begin
      unique case (st_q)
        ST_IDLE:  st_d = ST_IDLE;
        ST_ADDR:  if (full_q) st_d = addr_hit ? ST_AACK : ST_IDLE;
        ST_AACK:  st_d = sh_q[0] ? ST_RDATA : ST_CMD;
        ST_CMD:   if (full_q) st_d = ST_CACK;
        ST_CACK:  st_d = ST_WDATA;
        ST_WDATA: if (full_q) st_d = ST_WACK;
        ST_WACK:  st_d = ST_WDATA;
        ST_RDATA: if (full_q) st_d = ST_RACK;
        ST_RACK:  st_d = mack_q ? ST_RDATA : ST_IDLE;
        default:  st_d = ST_IDLE;
      endcase
    end
  end

  // register strobes: read fires when a data byte is loaded for sending
  assign rd_stb = scl_fall & ~i2c_start & ~i2c_stop
                & (((st_q == ST_AACK) & sh_q[0]) | ((st_q == ST_RACK) & mack_q));
  assign wr_stb = scl_fall & (st_q == ST_WDATA) & full_q;

  // open drain: oe_n low pulls the line, data bit one just releases
  always_comb begin
    oe_n_d = oe_n_q;
    if (i2c_start || i2c_stop) begin
      oe_n_d = 1'b1;
    end else if (rd_stb) begin
      oe_n_d = rd_data[7];
    end else if (scl_fall) begin
      if (st_d == ST_AACK || st_d == ST_CACK || st_d == ST_WACK) begin
        oe_n_d = 1'b0;
      end else if (st_d == ST_RDATA) begin
        oe_n_d = tx_q[6];
      end else begin
        oe_n_d = 1'b1;
      end
    end
  end

  // shift, count and pointer state
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 3'h0;
      full_q <= 1'b0;
      mack_q <= 1'b0;
      oe_n_q <= 1'b1;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= CMD_SUMMARY;
    end else begin
      st_q   <= st_d;
      oe_n_q <= oe_n_d;
      if (i2c_start) begin
        cnt_q  <= 3'h0;
        full_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == ST_RACK) begin
          mack_q <= ~sda_s2_q; // low means the master wants more
        end else if (st_q inside {ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA}) begin
          sh_q   <= {sh_q[6:0], sda_s2_q};
          cnt_q  <= cnt_q + 3'h1;
          full_q <= (cnt_q == 3'h7);
        end
      end else if (scl_fall) begin
        full_q <= 1'b0;
        if (st_q == ST_CMD && full_q) ptr_q <= sh_q;
        if (rd_stb) tx_q <= rd_data;
        else if (st_q == ST_RDATA) tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = oe_n_q;

  // code 00h has no write path
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mask_q              <= MASK_RST;
      global_irq_enable_q <= GIE_RST;
    end else if (wr_stb) begin
      if (ptr_q == CMD_MASK) mask_q <= sh_q;
      if (ptr_q == CMD_GEN_MASK) global_irq_enable_q <= sh_q[GIE_BIT];
    end
  end

  assign glob_clr = wr_stb & (ptr_q == CMD_RESET) & sh_q[RST_CLR_BIT];

  // event inputs packed in bank order, all from same-clock logic
  assign set_vec = {pwr_enable_change_ch_in, pgood_change_ch_in, disconnect_ch_in,
                    detect_cycle_ch_in, class_cycle_ch_in,
                    overload_cut_pair_b_in, overload_cut_pair_a_in,
                    current_limit_ch_in, overload_cut_ch_in, start_fault_ch_in,
                    sram_fault_flag_in, power_supply_uv_flag_in,
                    logic_supply_uv_flag_in, thermal_shutdown_flag_in};

  pei_flag_bank u_flags (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .set_in   (set_vec),
    .clr_in   (clr_vec),
    .flag_out (flags)
  );

  // per category summary, clear and read-back byte
  for (genvar c = 0; c < NCAT; c++) begin : g_cat
    assign event_summary[c] = |flags[CAT_OFS[c] +: CAT_W[c]];
    assign cat_clr[c] = rd_stb & ((ptr_q == CMD_EVT_BASE + 8'(c))
                      | ((c == CAT_CUR) & (ptr_q == CMD_EVT_PAIR)));
    assign clr_vec[CAT_OFS[c] +: CAT_W[c]] = {CAT_W[c]{cat_clr[c] | glob_clr}};
    // wide current slice shows its eight channel flags here
    assign cat_byte[c] = 8'(flags[CAT_OFS[c] +: CAT_W[c]]);
  end

  // read data selection; unmapped codes read zero
  assign evt_idx  = ptr_q - CMD_EVT_BASE;
  assign evt_hit  = (ptr_q >= CMD_EVT_BASE) && (evt_idx < 8'(NCAT));
  assign evt_byte = cat_byte[evt_idx[2:0]];
  assign rd_data  = (ptr_q == CMD_SUMMARY)  ? event_summary :
                    (ptr_q == CMD_MASK)     ? mask_q :
                    (ptr_q == CMD_GEN_MASK) ? {global_irq_enable_q, 7'h00} :
                    (ptr_q == CMD_EVT_PAIR) ? {6'h00, flags[F_PAIR +: 2]} :
                    evt_hit                 ? evt_byte : 8'h00;

  // masked summary gated by global enable
  assign irq_req = global_irq_enable_q & |(event_summary & mask_q);
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~irq_req;
    end
  end
  assign int_n_out = int_n_q;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_irq_cause;
    global_irq_enable_q && |(event_summary & mask_q);
  endsequence
  sequence s_irq_seen;
    !int_n_out;
  endsequence

  a_irq_assert: assert property (s_irq_cause |=> s_irq_seen)
    else $error("interrupt not driven for enabled event");
  a_irq_quiet: assert property (!global_irq_enable_q |=> int_n_out)
    else $error("interrupt driven while disabled");
  a_supply_sets: assert property (|set_vec[F_SUP +: 4] |=> event_summary[7])
    else $error("supply event missed");
  a_start_sets: assert property (|set_vec[F_STA +: 4] |=> event_summary[6])
    else $error("start fault missed");
  a_current_sets: assert property (|set_vec[F_CUR +: 10] |=> event_summary[5])
    else $error("current fault missed");
  a_class_sets: assert property (|class_cycle_ch_in |=> event_summary[4])
    else $error("classification event missed");
  a_detect_sets: assert property (|detect_cycle_ch_in |=> event_summary[3])
    else $error("detection event missed");
  a_disc_sets: assert property (|disconnect_ch_in |=> event_summary[2])
    else $error("disconnect event missed");
  a_pgood_sets: assert property (|pgood_change_ch_in |=> event_summary[1])
    else $error("power good change missed");
  a_pe_sets: assert property (|pwr_enable_change_ch_in |=> event_summary[0])
    else $error("power enable change missed");
  a_flags_hold: assert property (!rd_stb && !glob_clr |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a clear");
  a_global_clr: assert property (glob_clr && set_vec == '0 |=> event_summary == 8'h00)
    else $error("reset command left summary set");
  a_read_clr: assert property (cat_clr[0] && ~|set_vec[F_PE +: 4] |=> !event_summary[0])
    else $error("event read did not clear summary bit");
  a_summary_ro: assert property (wr_stb && ptr_q == CMD_SUMMARY |=>
      $stable(mask_q) && $stable(global_irq_enable_q)
      && ((flags & $past(flags)) == $past(flags)))
    else $error("write to summary code changed state");
endmodule // pei_event_irq

// File: sim/port_event_interrupt_test.sv
`timescale 1ns/1ps
module port_event_interrupt_test;
  import pei_pkg::*;
  localparam logic [6:0] ADDR  = 7'h20;
  localparam int         LIMIT = 90000;
  logic           sys_clk, rst_n, scl, sda_m, sda_o, sda_oe_n, int_n, sda_w;
  logic           thermal_shutdown_flag, logic_supply_uv_flag, power_supply_uv_flag, sram, pa, pb;
  logic [NCH-1:0] stf, cut, lim, cls, det, dis, pg, pe;
  logic [7:0]     rd;
  logic           ack;
  int             error_cnt = 0;
  int             tests_run = 0;
  int             cycles    = 0;

  // open drain line: master and device can both pull low
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  pei_event_irq #(.I2C_ADDR(ADDR)) pei_event_irq_i (
    .sys_clk_in               (sys_clk),
    .rst_n_in                 (rst_n),
    .scl_in                   (scl),
    .sda_in                   (sda_w),
    .sda_out                  (sda_o),
    .sda_oe_n_out             (sda_oe_n),
    .int_n_out                (int_n),
    .thermal_shutdown_flag_in (thermal_shutdown_flag),
    .logic_supply_uv_flag_in  (logic_supply_uv_flag),
    .power_supply_uv_flag_in  (power_supply_uv_flag),
    .sram_fault_flag_in       (sram),
    .start_fault_ch_in        (stf),
    .overload_cut_ch_in       (cut),
    .overload_cut_pair_a_in   (pa),
    .overload_cut_pair_b_in   (pb),
    .current_limit_ch_in      (lim),
    .class_cycle_ch_in        (cls),
    .detect_cycle_ch_in       (det),
    .disconnect_ch_in         (dis),
    .pgood_change_ch_in       (pg),
    .pwr_enable_change_ch_in  (pe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // hang guard, sized well above the full sequence
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic start_c;
    sda_m = 1'b1;
    scl = 1'b1;
    clk(6);
    sda_m = 1'b0;
    clk(6);
    scl = 1'b0;
  endtask

  // data moves a few clocks after scl falls so no false start or stop is seen
  task automatic stop_c;
    clk(2);
    sda_m = 1'b0;
    clk(4);
    scl = 1'b1;
    clk(6);
    sda_m = 1'b1;
    clk(6);
  endtask

  // eight bits out msb first, ninth clock released; returns the line as sampled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic a);
    logic [8:0] sh;
    logic [8:0] got;
    sh = {tx, 1'b1};
    got = '0;
    for (int i = 8; i >= 0; i--) begin
      clk(2);
      sda_m = sh[i];
      clk(4);
      scl = 1'b1;
      clk(6);
      got = {got[7:0], sda_w};
      scl = 1'b0;
    end
    rx = got[8:1];
    a = got[0];
  endtask

  task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d);
    start_c();
    xfer({ADDR, 1'b0}, rd, ack);
    chk({7'h00, ack}, 8'h00);
    xfer(cmd, rd, ack);
    chk({7'h00, ack}, 8'h00);
    xfer(d, rd, ack);
    chk({7'h00, ack}, 8'h00);
    stop_c();
  endtask

  task automatic reg_rd(input logic [7:0] cmd, output logic [7:0] d);
    start_c();
    xfer({ADDR, 1'b0}, rd, ack);
    chk({7'h00, ack}, 8'h00);
    xfer(cmd, rd, ack);
    chk({7'h00, ack}, 8'h00);
    stop_c();
    start_c();
    xfer({ADDR, 1'b1}, rd, ack);
    chk({7'h00, ack}, 8'h00);
    xfer(8'hff, d, ack);
    // device must let go of the line for the master's nack
    chk({7'h00, ack}, 8'h01);
    stop_c();
  endtask

  // expected event register byte for the source that set_cat drives
  function automatic logic [7:0] evt_exp(input int n, input int k);
    case (n)
      1:       evt_exp = 8'h01 << (k + 1);
      2:       evt_exp = 8'h01 << (3 - k);
      3, 6:    evt_exp = 8'h01 << (k + 2);
      5:       evt_exp = (k == 1) ? 8'h08 : 8'h02;
      7:       evt_exp = (k == 1) ? 8'h02 : 8'h08;
      default: evt_exp = 8'h01 << k;
    endcase
  endfunction

  // one event source per category; k picks a second source on the second pass
  task automatic set_cat(input int n, input int k, input logic v);
    case (n)
      0: pe[k] = v;
      1: pg[k+1] = v;
      2: dis[3-k] = v;
      3: det[k+2] = v;
      4: cls[k] = v;
      5: if (k == 1) cut[3] = v; else pb = v;
      6: stf[k+2] = v;
      default: if (k == 1) logic_supply_uv_flag = v; else sram = v;
    endcase
  endtask

  // one cycle pulse only: the summary must hold it by latching
  task automatic pulse(input int n, input int k);
    set_cat(n, k, 1'b1);
    clk(1);
    set_cat(n, k, 1'b0);
  endtask

  task automatic test_reset;
    chk({7'h00, int_n}, 8'h01);
    // a foreign address must get no acknowledge
    start_c();
    xfer({ADDR ^ 7'h01, 1'b0}, rd, ack);
    stop_c();
    chk({7'h00, ack}, 8'h01);
    reg_wr(CMD_SUMMARY, 8'h7f);
    reg_rd(CMD_SUMMARY, rd);
    chk(rd, 8'h80);
    reg_rd(CMD_MASK, rd);
    chk(rd, MASK_RST);
  endtask

  task automatic test_cats;
    logic [7:0] code;
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < NCAT; n++) begin
        reg_wr(CMD_RESET, 8'h80);
        reg_rd(CMD_SUMMARY, rd);
        chk(rd, 8'h00);
        pulse(n, k);
        clk(4);
        reg_rd(CMD_SUMMARY, rd);
        chk(rd, 8'h01 << n);
        // the pair cut source is read through its own code on the first pass
        code = (n == CAT_CUR && k == 0) ? CMD_EVT_PAIR : 8'(CMD_EVT_BASE + n);
        reg_rd(code, rd);
        chk(rd, evt_exp(n, k));
        reg_rd(CMD_SUMMARY, rd);
        chk(rd, 8'h00);
      end
    end
  endtask

  task automatic test_irq;
    reg_wr(CMD_GEN_MASK, 8'h80);
    reg_wr(CMD_MASK, 8'h08);
    reg_rd(CMD_MASK, rd);
    chk(rd, 8'h08);
    reg_rd(CMD_GEN_MASK, rd);
    chk(rd, 8'h80);
    pulse(6, 0);
    clk(4);
    chk({7'h00, int_n}, 8'h01);
    pulse(3, 1);
    clk(4);
    chk({7'h00, int_n}, 8'h00);
    reg_wr(CMD_GEN_MASK, 8'h00);
    clk(4);
    chk({7'h00, int_n}, 8'h01);
    reg_wr(CMD_GEN_MASK, 8'h80);
    clk(4);
    chk({7'h00, int_n}, 8'h00);
    reg_rd(8'(CMD_EVT_BASE + 3), rd);
    clk(4);
    chk({7'h00, int_n}, 8'h01);
  endtask

  initial begin
    {rst_n, thermal_shutdown_flag, logic_supply_uv_flag, power_supply_uv_flag, sram, pa, pb} = '0;
    {stf, cut, lim, cls, det, dis, pg, pe} = '0;
    scl = 1'b1;
    sda_m = 1'b1;
    clk(3);
    rst_n = 1'b1;
    clk(8);
    test_reset();
    test_cats();
    test_irq();
    print_verdict();
  end
endmodule // port_event_interrupt_test
